// [hw/apsc_ctrl.sv]
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// host controller for the pseudo sram
// ****************************************
module apsc_ctrl
  import apsc_pkg::*;
#(
  parameter int PWRUP_CYCLES = apsc_pkg::PWRUP_CYC,
  parameter int FIFO_DEPTH   = 8
) (
  // clock and reset
  input  wire logic                         clock,
  input  wire logic                         nrst,
  // user request: write flag, lane enables (upper,lower), address, data
  input  wire logic                         req_valid,
  output logic                              req_ready,
  input  wire logic                         req_write,
  input  wire logic [1:0]                   req_lanes,
  input  wire logic [apsc_pkg::ADDR_W-1:0]  req_addr,
  input  wire logic [apsc_pkg::DATA_W-1:0]  req_wdata,
  // user power control and status
  input  wire logic                         sleep_req,
  output logic                              mem_ready,
  // read answer
  output logic                              rd_valid,
  output logic [apsc_pkg::DATA_W-1:0]       rd_data,
  // memory pins
  output logic                              chip_select_n,
  output logic                              output_enable_n,
  output logic                              write_enable_n,
  output logic                              upper_lane_select_n,
  output logic                              lower_lane_select_n,
  output logic                              deep_sleep_n,
  output logic [apsc_pkg::ADDR_W-1:0]       addr_bus,
  input  wire logic [apsc_pkg::DATA_W-1:0]  data_bus_in,
  output logic [apsc_pkg::DATA_W-1:0]       data_bus_out,
  output logic                              data_bus_oe
);
  localparam int RW  = 1 + 2 + ADDR_W + DATA_W;
  localparam int CW  = 24;
  initial begin
    if (PWRUP_CYCLES < 1 || PWRUP_CYCLES >= (1 << CW)) $error("bad power-up count");
  end
  logic            f_valid, f_ready;
  logic [RW-1:0]   f_data;
  // ****************************************
  // request buffer
  // ****************************************
  apsc_fifo #(.WIDTH(RW), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clock     (clock),
    .nrst      (nrst),
    .in_valid  (req_valid),
    .in_ready  (req_ready),
    .in_data   ({req_write, req_lanes, req_addr, req_wdata}),
    .out_valid (f_valid),
    .out_ready (f_ready),
    .out_data  (f_data)
  );
  apsc_state_type        state_reg, state_next;
  logic [CW-1:0]         cnt_reg, cnt_next;
  logic [1:0]            dummy_reg, dummy_next;
  logic [5:0]            run_reg, run_next;
  logic                  wr_reg, wr_next;
  logic [1:0]            lanes_reg, lanes_next;
  logic [ADDR_W-1:0]     addr_reg, addr_next;
  logic [DATA_W-1:0]     wdat_reg, wdat_next, rdat_reg, rdat_next;
  logic                  rdv_reg, rdv_next;
  // ****************************************
  // sequencer
  // ****************************************
  always_comb begin
    state_next = state_reg;
    cnt_next   = cnt_reg;
    dummy_next = dummy_reg;
    run_next   = run_reg;
    wr_next    = wr_reg;
    lanes_next = lanes_reg;
    addr_next  = addr_reg;
    wdat_next  = wdat_reg;
    rdat_next  = rdat_reg;
    rdv_next   = 1'b0;
    f_ready    = 1'b0;
    case (state_reg)
      // power-up wait, counted from the first edge out of reset
      // dummy reads used, longer wait not needed
      APSC_WAIT: begin
        if (cnt_reg >= CW'(PWRUP_CYCLES)) begin
          state_next = APSC_DUMMY;
          cnt_next   = '0;
          dummy_next = '0;
        end else
          cnt_next = cnt_reg + 1'b1;
      end
      // two dummy reads, each a full cycle
      APSC_DUMMY: begin
        if (cnt_reg >= CW'(CYC_CYC - 1)) begin
          cnt_next   = '0;
          dummy_next = dummy_reg + 1'b1;
          state_next = APSC_REC;  // chip select released between dummy reads
        end else
          cnt_next = cnt_reg + 1'b1;
      end
      APSC_IDLE: begin
        cnt_next = '0;
        if (sleep_req) begin
          state_next = APSC_SLEEP;
        end else if (f_valid) begin
          f_ready    = 1'b1;
          {wr_next, lanes_next, addr_next, wdat_next} = f_data;
          if (f_data[RW-1]) begin
            run_next   = (run_reg == 6'(MAX_WR_RUN)) ? 6'd1 : run_reg + 1'b1;
            state_next = APSC_WR;
          end else begin
            run_next   = '0;
            state_next = APSC_RD;
          end
        end
      end
      APSC_RD: begin
        if (cnt_reg >= CW'(ACC_CYC - 1)) begin
          rdat_next  = data_bus_in;
          rdv_next   = 1'b1;
          state_next = APSC_REC;
          cnt_next   = '0;
        end else
          cnt_next = cnt_reg + 1'b1;
      end
      APSC_WR: begin
        if (cnt_reg >= CW'(WP_CYC - 1)) begin
          state_next = APSC_REC;
          cnt_next   = '0;
        end else
          cnt_next = cnt_reg + 1'b1;
      end
      // recovery with chip deselected; CYC_CYC cycles after every access, also after a write-run limit
      APSC_REC: begin
        if (cnt_reg >= CW'(CYC_CYC - 1)) begin
          // next dummy read until all are done
          state_next = (dummy_reg == 2'(DUMMY_READS)) ? APSC_IDLE : APSC_DUMMY;
          cnt_next   = '0;
        end else
          cnt_next = cnt_reg + 1'b1;
      end
      // suspend period, data lost, rewake on release
      APSC_SLEEP: begin
        if (cnt_reg < CW'(SLEEP_CYC)) cnt_next = cnt_reg + 1'b1;
        else if (!sleep_req) begin
          state_next = APSC_WAIT;
          cnt_next   = '0;
        end
      end
      default: state_next = APSC_WAIT;
    endcase
  end
  // state registers
  always_ff @(posedge clock) begin
    if (!nrst) begin
      state_reg <= APSC_WAIT;
      cnt_reg   <= '0;
      dummy_reg <= '0;
      run_reg   <= '0;
      wr_reg    <= 1'b0;
      lanes_reg <= '0;
      addr_reg  <= '0;
      wdat_reg  <= '0;
      rdat_reg  <= '0;
      rdv_reg   <= 1'b0;
    end else begin
      state_reg <= state_next;
      cnt_reg   <= cnt_next;
      dummy_reg <= dummy_next;
      run_reg   <= run_next;
      wr_reg    <= wr_next;
      lanes_reg <= lanes_next;
      addr_reg  <= addr_next;
      wdat_reg  <= wdat_next;
      rdat_reg  <= rdat_next;
      rdv_reg   <= rdv_next;
    end
  end
  // ****************************************
  // pin drive
  // ****************************************
  // all pins at firm levels; lane selects
  always_comb begin
    chip_select_n       = !(state_reg == APSC_RD || state_reg == APSC_WR
                            || state_reg == APSC_DUMMY);
    output_enable_n     = !(state_reg == APSC_RD || state_reg == APSC_DUMMY);
    write_enable_n      = !(state_reg == APSC_WR);
    upper_lane_select_n = (state_reg == APSC_DUMMY) ? 1'b0 : !lanes_reg[1];
    lower_lane_select_n = (state_reg == APSC_DUMMY) ? 1'b0 : !lanes_reg[0];
    deep_sleep_n        = !(state_reg == APSC_SLEEP);
    addr_bus            = addr_reg;
    data_bus_out        = wdat_reg;
    data_bus_oe         = (state_reg == APSC_WR);
    mem_ready           = (state_reg == APSC_IDLE);
    rd_valid            = rdv_reg;
    rd_data             = rdat_reg;
  end
  // ****************************************
  // checks
  // ****************************************
  logic [CW-1:0] hi_cnt_reg, hi_cnt_next;
  // chip-select high time, saturating
  always_comb begin
    hi_cnt_next = hi_cnt_reg;
    if (!chip_select_n) begin
      hi_cnt_next = '0;
    end else if (hi_cnt_reg != '1) begin
      hi_cnt_next = hi_cnt_reg + 1'b1;
    end
  end
  // chip-select high time register
  always_ff @(posedge clock) begin
    if (!nrst) begin
      hi_cnt_reg <= '0;
    end else begin
      hi_cnt_reg <= hi_cnt_next;
    end
  end
  // first dummy read only after the full wait
  a_wake_wait_cs: assert property (@(posedge clock) disable iff (!nrst)
    $fell(chip_select_n) && dummy_reg == 2'd0 |-> hi_cnt_reg >= CW'(PWRUP_CYCLES))
    else $error("chip select low before power-up wait ended");
  a_pulse_width_min: assert property (@(posedge clock) disable iff (!nrst)
    $fell(write_enable_n) |-> !write_enable_n [*2])
    else $error("write pulse too short");
  a_read_cycle_len: assert property (@(posedge clock) disable iff (!nrst)
    (state_reg == APSC_IDLE && $past(state_reg) == APSC_IDLE && state_next == APSC_RD)
    |=> !output_enable_n [*3])
    else $error("read cycle too short");
  // bus owned by us on writes
  a_wr_oe_excl: assert property (@(posedge clock) disable iff (!nrst)
    !write_enable_n |-> output_enable_n && data_bus_oe)
    else $error("bus drive conflict on write");
  a_sleep_pins: assert property (@(posedge clock) disable iff (!nrst)
    !deep_sleep_n |-> chip_select_n && !data_bus_oe)
    else $error("activity during deep sleep");
  a_dummy_count: assert property (@(posedge clock) disable iff (!nrst)
    $rose(mem_ready) && $past(state_reg, 2) != APSC_RD && $past(state_reg, 2) != APSC_WR
    |-> dummy_reg == 2'(DUMMY_READS))
    else $error("ready before dummy reads");
  a_run_limit: assert property (@(posedge clock) disable iff (!nrst)
    run_reg <= 6'(MAX_WR_RUN))
    else $error("write run over limit");
  a_rd_sample: assert property (@(posedge clock) disable iff (!nrst)
    $rose(rd_valid) |-> $past(state_reg) == APSC_RD)
    else $error("read data not from read cycle");
  c_word_write: cover property (@(posedge clock) disable iff (!nrst)
    !write_enable_n && !upper_lane_select_n && !lower_lane_select_n);
  c_byte_read: cover property (@(posedge clock) disable iff (!nrst)
    rd_valid && lanes_reg == 2'b01);
  c_sleep_wake: cover property (@(posedge clock) disable iff (!nrst)
    !deep_sleep_n ##1 deep_sleep_n);
  c_fifo_full: cover property (@(posedge clock) disable iff (!nrst) !req_ready);
endmodule
`default_nettype wire

// [hw/apsc_pkg.sv]
`default_nettype none
package apsc_pkg;
  localparam int ADDR_W        = 20;
  localparam int DATA_W        = 16;
  localparam int CLK_NS        = 25;
  localparam int PWRUP_US      = 200;
  localparam int SLEEP_US_X10  = 5;    // 0.5 us suspend
  localparam int CYC_NS        = 70;   // fast grade cycle time
  localparam int WP_NS         = 50;   // fast grade write pulse
  localparam int ACC_NS        = 70;   // fast grade address access
  localparam int MAX_WR_RUN    = 50;
  localparam int DUMMY_READS   = 2;
  localparam int PWRUP_CYC     = (PWRUP_US * 1000 + CLK_NS - 1) / CLK_NS;
  localparam int SLEEP_CYC     = (SLEEP_US_X10 * 100 + CLK_NS - 1) / CLK_NS;
  localparam int CYC_CYC       = (CYC_NS + CLK_NS - 1) / CLK_NS;
  localparam int WP_CYC        = (WP_NS + CLK_NS - 1) / CLK_NS;
  localparam int ACC_CYC       = (ACC_NS + CLK_NS - 1) / CLK_NS + 1;
  typedef enum logic [2:0] {
    APSC_WAIT  = 3'b000,
    APSC_DUMMY = 3'b001,
    APSC_IDLE  = 3'b011,
    APSC_RD    = 3'b010,
    APSC_WR    = 3'b110,
    APSC_REC   = 3'b111,
    APSC_SLEEP = 3'b101
  } apsc_state_type;
endpackage
`default_nettype wire

// [hw/apsc_fifo.sv]
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// small synchronous fifo
// ****************************************
module apsc_fifo #(
  parameter int WIDTH = 37,
  parameter int DEPTH = 8
) (
  // clock and reset
  input  wire logic             clock,
  input  wire logic             nrst,
  // fill side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // drain side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);
  localparam int AW = $clog2(DEPTH);
  initial begin
    if (DEPTH < 2 || (1 << AW) != DEPTH) $error("depth must be a power of two");
  end
  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW:0]      wr_reg, wr_next, rd_reg, rd_next;
  logic             push, pop;
  // pointers and flags
  always_comb begin
    push      = in_valid && in_ready;
    pop       = out_valid && out_ready;
    in_ready  = (wr_reg - rd_reg) != (AW+1)'(DEPTH);
    out_valid = wr_reg != rd_reg;
    out_data  = mem_reg[rd_reg[AW-1:0]];
    wr_next   = push ? wr_reg + 1'b1 : wr_reg;
    rd_next   = pop ? rd_reg + 1'b1 : rd_reg;
  end
  // storage and pointer registers
  always_ff @(posedge clock) begin
    if (push) mem_reg[wr_reg[AW-1:0]] <= in_data;
    if (!nrst) begin
      wr_reg <= '0;
      rd_reg <= '0;
    end else begin
      wr_reg <= wr_next;
      rd_reg <= rd_next;
    end
  end
endmodule
`default_nettype wire

// [bench/apsc_mem_model.sv]
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// pseudo sram seen from its pins
// ****************************************
module apsc_mem_model
  import apsc_pkg::*;
(
  // clock and answer speed
  input  wire logic                        clock,
  input  wire logic                        slow,
  // memory pins
  input  wire logic                        chip_select_n,
  input  wire logic                        output_enable_n,
  input  wire logic                        write_enable_n,
  input  wire logic                        upper_lane_select_n,
  input  wire logic                        lower_lane_select_n,
  input  wire logic                        deep_sleep_n,
  input  wire logic [apsc_pkg::ADDR_W-1:0] addr_bus,
  input  wire logic [apsc_pkg::DATA_W-1:0] data_bus_out,
  input  wire logic                        data_bus_oe,
  output logic [apsc_pkg::DATA_W-1:0]      data_bus_in,
  output logic                             driving
);
  logic [DATA_W-1:0] mem [logic [ADDR_W-1:0]];
  logic [DATA_W-1:0] last_reg = 16'h0000;
  logic [DATA_W-1:0] cur;
  logic [DATA_W-1:0] wr;
  logic [ADDR_W-1:0] addr_reg = 20'h00000;
  int                held_reg = 0;
  logic              rd_cyc;
  // stored word, or a scrambled blank where nothing was written
  function automatic logic [DATA_W-1:0] peek(input logic [ADDR_W-1:0] a);
    return mem.exists(a) ? mem[a] : ({a[3:0], a[15:4]} ^ 16'hA5C3);
  endfunction
  // read decode and lane drive; released lanes show a changing pattern
  always @* begin
    cur = peek(addr_bus);
    rd_cyc = deep_sleep_n && !chip_select_n && !output_enable_n && write_enable_n
             && !(upper_lane_select_n && lower_lane_select_n);
    driving = rd_cyc && (held_reg >= (slow ? 3 : 2));
    data_bus_in = ~last_reg;
    if (driving && !lower_lane_select_n) begin
      data_bus_in[7:0] = cur[7:0];
    end
    if (driving && !upper_lane_select_n) begin
      data_bus_in[15:8] = cur[15:8];
    end
  end
  // array update and access timer
  always @(posedge clock) begin
    last_reg <= data_bus_in;
    addr_reg <= addr_bus;
    // cycles of a read since the address settled
    held_reg <= !rd_cyc ? 0 : (addr_bus == addr_reg) ? held_reg + 1 : 1;
    wr = data_bus_oe ? data_bus_out : ~last_reg;
    if (!deep_sleep_n) begin
      mem.delete();
    // write lanes while select and strobe low
    end else if (!chip_select_n && !write_enable_n) begin
      mem[addr_bus] = {upper_lane_select_n ? cur[15:8] : wr[15:8],
                       lower_lane_select_n ? cur[7:0] : wr[7:0]};
    end
  end
endmodule
`default_nettype wire

// [bench/apsc_ctrl_test.sv]
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// self-checking bench for the controller
// ****************************************
module apsc_ctrl_test;
  import apsc_pkg::*;
  localparam int PW = 20;
  logic clock = 0, nrst = 0, req_valid = 0, req_write = 0, sleep_req = 0, slow = 0;
  logic [1:0]        req_lanes = 2'h0;
  logic [ADDR_W-1:0] req_addr = 20'h00000, addr_bus;
  logic [DATA_W-1:0] req_wdata = 16'h0000, rd_data, data_bus_in, data_bus_out;
  logic req_ready, mem_ready, rd_valid, chip_select_n, output_enable_n, write_enable_n;
  logic upper_lane_select_n, lower_lane_select_n, deep_sleep_n, data_bus_oe, driving;
  logic p_cs = 1, p_we = 1, p_ds = 1, p_rdy = 0, powering = 1;
  int   seed = 83309, n_errors = 0, comparisons = 0, i;
  int   cs_run = 0, dummies = 0, gap = 99, we_len = 0, sl_len = 0, wr_run = 0;
  logic [31:0]       r, e;
  logic [DATA_W-1:0] ref_mem [logic [ADDR_W-1:0]];
  logic [31:0]       exp_q [$];

  always #12.5 clock = ~clock;

  apsc_ctrl #(.PWRUP_CYCLES(PW)) DUT (
    .clock, .nrst, .req_valid, .req_ready, .req_write, .req_lanes, .req_addr, .req_wdata,
    .sleep_req, .mem_ready, .rd_valid, .rd_data, .chip_select_n, .output_enable_n,
    .write_enable_n, .upper_lane_select_n, .lower_lane_select_n, .deep_sleep_n,
    .addr_bus, .data_bus_in, .data_bus_out, .data_bus_oe
  );
  apsc_mem_model far (
    .clock, .slow, .chip_select_n, .output_enable_n, .write_enable_n, .upper_lane_select_n,
    .lower_lane_select_n, .deep_sleep_n, .addr_bus, .data_bus_out, .data_bus_oe,
    .data_bus_in, .driving
  );

  // compare and count
  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    comparisons++;
    if (seen !== want) begin
      n_errors++;
      $display("ERROR %0t: seen %h want %h", $time, seen, want);
    end
  endtask
  // verdict and end of run
  task automatic complete_run;
    $display("errors %0d comparisons %0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic timeout;
    n_errors++;
    complete_run;
  endtask
  // word the far side returns where nothing was written
  function automatic logic [DATA_W-1:0] blank(input logic [ADDR_W-1:0] a);
    return {a[3:0], a[15:4]} ^ 16'hA5C3;
  endfunction
  // offer one request and hold it until taken; leaves valid high
  task automatic push(input logic w, input logic [1:0] ln, input logic [ADDR_W-1:0] a,
                      input logic [DATA_W-1:0] d);
    logic [DATA_W-1:0] m, old;
    int k;
    m = {{8{ln[1]}}, {8{ln[0]}}};
    old = ref_mem.exists(a) ? ref_mem[a] : blank(a);
    req_write = w;
    req_lanes = ln;
    req_addr = a;
    req_wdata = d;
    req_valid = 1;
    #1;
    for (k = 0; k < 500 && req_ready !== 1'b1; k++) begin
      @(negedge clock);
      #1;
    end
    if (k == 500) timeout;
    @(negedge clock);
    if (w) ref_mem[a] = (old & ~m) | (d & m);
    else exp_q.push_back({m, old & m});
  endtask
  // wait until idle for three cycles with no read outstanding
  task automatic wait_idle;
    int k, s;
    s = 0;
    for (k = 0; k < 3000 && s < 3; k++) begin
      @(negedge clock);
      s = (mem_ready === 1'b1 && exp_q.size() == 0) ? s + 1 : 0;
    end
    if (k == 3000) timeout;
  endtask

  // read answers against the expected queue, sampled mid-cycle
  always @(negedge clock) begin
    if (rd_valid === 1'b1) begin
      e = (exp_q.size() > 0) ? exp_q.pop_front() : 32'hFFFF0000;
      check(rd_data & e[31:16], e[15:0]);
    end
  end
  // pin monitor: levels, spacing, pulse widths and power sequence, mid-cycle
  always @(negedge clock) begin
    if (nrst) begin
      check($isunknown({chip_select_n, output_enable_n, write_enable_n, deep_sleep_n,
                        upper_lane_select_n, lower_lane_select_n, addr_bus}), 0);
      check(data_bus_oe & driving, 0);
      if (!chip_select_n && p_cs) begin
        if (powering && dummies == 0) check(cs_run >= PW, 1);
        check(gap >= CYC_CYC, 1);
        if (powering) dummies++;
        gap = 0;
      end
      if (write_enable_n && !p_we) begin
        check(we_len >= WP_CYC, 1);
        wr_run++;
        check(wr_run <= MAX_WR_RUN, 1);
      end
      if (deep_sleep_n && !p_ds) check(sl_len >= SLEEP_CYC, 1);
      if (!deep_sleep_n) powering = 1;
      if (mem_ready && !p_rdy && powering) begin
        check(dummies >= DUMMY_READS, 1);
        dummies = 0;
        powering = 0;
      end
      if (chip_select_n) wr_run = 0;
      cs_run = chip_select_n ? cs_run + 1 : 0;
      we_len = write_enable_n ? 0 : we_len + 1;
      sl_len = deep_sleep_n ? 0 : sl_len + 1;
      gap++;
      p_cs = chip_select_n;
      p_we = write_enable_n;
      p_ds = deep_sleep_n;
      p_rdy = mem_ready;
    end
  end

  // main sequence
  initial begin
    repeat (12) @(negedge clock);
    nrst <= 1'b1;
    // fill the fifo while powering up; the held ninth offer is refused
    for (i = 0; i < 8; i++) push(1, 2'h3, i[19:0], 16'h1234 ^ i[15:0]);
    #1 check(req_ready, 0);
    req_valid = 0;
    wait_idle;
    // random traffic with a boundary address and both answer speeds
    for (i = 0; i < 200; i++) begin
      r = $random(seed);
      slow = r[6];
      push(r[0], (r[2:1] == 2'h0) ? 2'h3 : r[2:1], r[7] ? 20'hFFFFF : {17'h0, r[5:3]},
           r[31:16]);
    end
    req_valid = 0;
    wait_idle;
    // deep power-down, wake and read back blanks
    sleep_req = 1;
    for (i = 0; i < 100 && deep_sleep_n !== 1'b0; i++) @(negedge clock);
    if (i == 100) timeout;
    ref_mem.delete();
    repeat (30) @(negedge clock);
    sleep_req = 0;
    wait_idle;
    for (i = 0; i < 8; i++) push(0, 2'h3, i[19:0], 16'h0000);
    req_valid = 0;
    wait_idle;
    complete_run;
  end
endmodule
`default_nettype wire
